// [src/skip_ops_defines.svh]
`ifndef SKIP_OPS_DEFINES_SVH
`define SKIP_OPS_DEFINES_SVH
// first bytes of the handled opcodes
`define OP_CMP_RIM      8'hD9
`define OP_ESC_A        8'hDD
`define OP_ESC_EA       8'hDC
`define OP_CMP_A_HL     8'h38
`define OP_INC_DA       8'hCA
`define OP_ESC_INT      8'hFE
`define OP_ESC_PWR      8'hFF
// second bytes
`define SB_INT_IDLE     8'hB2
`define SB_IDLE         8'hA3
`define SB_EA_HL        8'h09
`define SB_INC_HL       8'h62
// field positions
`define IME_BIT         3
`define IDLE_BIT        2
// apb offsets
`define ADDR_CTRL       12'h000
`define ADDR_STATUS     12'h004
`define ADDR_REGS       12'h008
`define ADDR_PTR        12'h00C
`define ADDR_FETCH      12'h010
`define ADDR_ACC        12'h014
`define ADDR_MEMSEL     12'h018
`define ADDR_MEMDAT     12'h01C
`endif

// [src/skip_ops_pkg.sv]
package skip_ops_pkg;
    typedef enum logic [1:0] {
        st_first,
        st_second,
        st_skip1,
        st_skip2
    } exec_state_type;
    typedef logic [3:0] nibble_type;
endpackage

// [src/skip_interrupt_idle_ops.sv]
`include "skip_ops_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module skip_interrupt_idle_ops
    import skip_ops_pkg::*;
#(
    parameter int MEM_AW = 8                  // data memory address width
) (
    input  wire logic        pclk,            // clock
    input  wire logic        presetn,         // async reset, low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb enable
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error
    input  wire logic [4:0]  int_source,      // peripheral interrupt events
    output logic             int_vector_req,  // core may vector
    output logic             cpu_clk_en       // cpu clock running
);
    import skip_ops_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // storage
    exec_state_type state_reg, state_next;
    logic [3:0]  wreg_reg [8];
    logic [3:0]  mem_reg [2**MEM_AW];
    logic [7:0]  ptr_reg;
    logic [7:0]  op1_reg;
    logic [15:0] pc_reg;
    logic        carry_reg;
    logic        ime_reg;
    logic        idle_reg;
    logic [4:0]  pend_reg;
    logic [7:0]  fetch_reg;
    logic        fetch_full_reg;
    logic [3:0]  acc_reg, acch_reg;
    logic [7:0]  memsel_reg;
    logic [31:0] prdata_reg;
    logic [7:0]  exec_count_reg;
    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire acc_ph   = psel && penable;
    wire wr_en    = acc_ph && pwrite;
    wire rd_en    = acc_ph && !pwrite;
    wire hit_ctrl = paddr == `ADDR_CTRL;
    wire hit_stat = paddr == `ADDR_STATUS;
    wire hit_regs = paddr == `ADDR_REGS;
    wire hit_ptr  = paddr == `ADDR_PTR;
    wire hit_fet  = paddr == `ADDR_FETCH;
    wire hit_acc  = paddr == `ADDR_ACC;
    wire hit_msel = paddr == `ADDR_MEMSEL;
    wire hit_mdat = paddr == `ADDR_MEMDAT;
    wire mapped   = hit_ctrl | hit_stat | hit_regs | hit_ptr | hit_fet | hit_acc | hit_msel | hit_mdat;
    // fetch write is stalled while a byte waits
    wire fetch_blk = hit_fet && wr_en && fetch_full_reg;
    assign pready  = !fetch_blk;
    assign pslverr = acc_ph && !mapped;
    assign prdata  = prdata_reg;
    ////////////////////////////////////////////////////////////////////////////
    // fetched byte and its field views
    wire       byte_ok = fetch_full_reg && !idle_reg;
    wire [7:0] b       = fetch_reg;
    wire [2:0] rsel    = b[2:0];
    wire [2:0] psel_e  = {b[2:1], 1'b0};
    wire [2:0] psel_o  = {b[2:1], 1'b1};
    wire [3:0] hl_mem  = mem_reg[ptr_reg];
    wire [3:0] hl1_mem = mem_reg[ptr_reg + 8'h01];
    wire [7:0] pair_v  = {wreg_reg[psel_o], wreg_reg[psel_e]};
    wire [7:0] pair_dec = pair_v - 8'h01;
    wire [7:0] pair_inc = pair_v + 8'h01;
    wire [3:0] r_dec    = wreg_reg[rsel] - 4'h1;
    wire [3:0] r_inc    = wreg_reg[rsel] + 4'h1;
    ////////////////////////////////////////////////////////////////////////////
    // skip length of the next instruction: two byte opcodes, else one
    wire next_two = (b == `OP_CMP_RIM) || (b == `OP_ESC_A) || (b == `OP_ESC_EA) || (b == `OP_INC_DA)
                 || (b == `OP_ESC_INT) || (b == `OP_ESC_PWR);
    ////////////////////////////////////////////////////////////////////////////
    // second byte decode
    logic       sk2;
    logic       two_byte_first;
    always_comb begin
        sk2 = 1'b0;
        two_byte_first = (b == `OP_CMP_RIM) || (b == `OP_ESC_A) || (b == `OP_ESC_EA)
                      || (b == `OP_INC_DA) || (b == `OP_ESC_INT) || (b == `OP_ESC_PWR);
        unique case (op1_reg)
            `OP_CMP_RIM: sk2 = (b[3] == 1'b0) && (wreg_reg[rsel] == b[7:4]);
            `OP_ESC_A: begin
                if (b[7:4] == 4'h7) begin
                    sk2 = hl_mem == b[3:0];
                end else if (b[7:3] == 5'b01101) begin
                    sk2 = acc_reg == wreg_reg[rsel];
                end else if (b == `SB_INC_HL) begin
                    sk2 = hl_mem == 4'hF;
                end
            end
            `OP_ESC_EA: begin
                if (b == `SB_EA_HL) begin
                    sk2 = (acc_reg == hl_mem) && (acch_reg == hl1_mem);
                end else if (b[7:3] == 5'b11101 && !b[0]) begin
                    sk2 = {acch_reg, acc_reg} == pair_v;
                end else if (b[7:3] == 5'b11011 && !b[0]) begin
                    sk2 = pair_v == 8'h00;
                end
            end
            `OP_INC_DA: sk2 = mem_reg[b] == 4'hF;
            default: sk2 = 1'b0;
        endcase
    end
    // single byte skip conditions
    // accumulator vs memory
    wire cmp_a_hl = b == `OP_CMP_A_HL;
    wire dec_r    = b[7:3] == 5'b01001;
    wire inc_r    = b[7:3] == 5'b01011;
    wire inc_rr   = b[7:3] == 5'b10000 && !b[0];
    wire sk1 = (cmp_a_hl && acc_reg == hl_mem) || (dec_r && wreg_reg[rsel] == 4'h0)
            || (inc_r && wreg_reg[rsel] == 4'hF) || (inc_rr && pair_v == 8'hFF);
    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    // skip or fall through
    always_comb begin
        state_next = state_reg;
        if (byte_ok) begin
            unique case (state_reg)
                st_first:  state_next = two_byte_first ? st_second : (sk1 ? st_skip1 : st_first);
                st_second: state_next = sk2 ? st_skip1 : st_first;
                st_skip1:  state_next = next_two ? st_skip2 : st_first;
                st_skip2:  state_next = st_first;
            endcase
        end
    end
    // execution stalls in idle, peripherals below keep latching
    assign cpu_clk_en = !idle_reg;
    // vector only with master enable and a pending latch
    assign int_vector_req = ime_reg && (pend_reg != 5'h00) && !idle_reg;
    ////////////////////////////////////////////////////////////////////////////
    // state and pc
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= st_first;
            pc_reg    <= 16'h0000;
            op1_reg   <= 8'h00;
            exec_count_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (byte_ok) begin
                pc_reg  <= pc_reg + 16'h0001;
                op1_reg <= b;
                exec_count_reg <= exec_count_reg + 8'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // working registers and data memory
    always_ff @(posedge pclk) begin
        if (wr_en && hit_regs) begin
            wreg_reg[pwdata[6:4]] <= pwdata[3:0];
        end else if (byte_ok && state_reg == st_first) begin
            if (dec_r) wreg_reg[rsel] <= r_dec;
            if (inc_r) wreg_reg[rsel] <= r_inc;
            if (inc_rr) begin
                wreg_reg[psel_e] <= pair_inc[3:0];
                wreg_reg[psel_o] <= pair_inc[7:4];
            end
        end else if (byte_ok && state_reg == st_second && op1_reg == `OP_ESC_EA && b[7:3] == 5'b11011 && !b[0]) begin
            wreg_reg[psel_e] <= pair_dec[3:0];
            wreg_reg[psel_o] <= pair_dec[7:4];
        end
        if (wr_en && hit_mdat) begin
            mem_reg[memsel_reg] <= pwdata[3:0];
        end else if (byte_ok && state_reg == st_second) begin
            if (op1_reg == `OP_INC_DA) mem_reg[b] <= mem_reg[b] + 4'h1;
            if (op1_reg == `OP_ESC_A && b == `SB_INC_HL) mem_reg[ptr_reg] <= hl_mem + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // control flags and apb registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ime_reg  <= 1'b0;
            idle_reg <= 1'b0;
            carry_reg <= 1'b0;
            pend_reg <= 5'h00;
            ptr_reg  <= 8'h00;
            acc_reg  <= 4'h0;
            acch_reg <= 4'h0;
            memsel_reg <= 8'h00;
        end else begin
            if (byte_ok && state_reg == st_second && op1_reg == `OP_ESC_INT && b == `SB_INT_IDLE) ime_reg <= 1'b0;
            else if (byte_ok && state_reg == st_second && op1_reg == `OP_ESC_PWR && b == `SB_INT_IDLE)
                ime_reg <= 1'b1;
            else if (wr_en && hit_ctrl) ime_reg <= pwdata[`IME_BIT];
            if (byte_ok && state_reg == st_second && op1_reg == `OP_ESC_PWR && b == `SB_IDLE) idle_reg <= 1'b1;
            else if (wr_en && hit_ctrl) idle_reg <= pwdata[`IDLE_BIT];
            // latches set regardless of enable, set wins over clear
            pend_reg <= (pend_reg & ~((wr_en && hit_stat) ? pwdata[4:0] : 5'h00)) | int_source;
            if (wr_en && hit_ptr) ptr_reg <= pwdata[7:0];
            if (wr_en && hit_acc) {acch_reg, acc_reg} <= pwdata[7:0];
            if (wr_en && hit_msel) memsel_reg <= pwdata[7:0];
        end
    end
    // fetch slot: apb write fills, execution drains
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_full_reg <= 1'b0;
            fetch_reg      <= 8'h00;
        end else if (wr_en && hit_fet && !fetch_full_reg) begin
            fetch_full_reg <= 1'b1;
            fetch_reg      <= pwdata[7:0];
        end else if (byte_ok) begin
            fetch_full_reg <= 1'b0;
        end
    end
    // read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= hit_ctrl ? {28'h0, ime_reg, idle_reg, 2'b00} :
                          hit_stat ? {4'h0, exec_count_reg, pc_reg[7:0], 1'b0, state_reg, carry_reg, 2'b00, 1'b0, pend_reg} :
                          hit_regs ? {28'h0, wreg_reg[pwdata[6:4]]} :
                          hit_ptr  ? {24'h0, ptr_reg} :
                          hit_fet  ? {23'h0, fetch_full_reg, fetch_reg} :
                          hit_acc  ? {24'h0, acch_reg, acc_reg} :
                          hit_msel ? {24'h0, memsel_reg} :
                          hit_mdat ? {28'h0, mem_reg[memsel_reg]} : 32'h0000_0000;
        end
    end
endmodule // skip_interrupt_idle_ops

// [tb/skip_ops_monitor.sv]
`include "skip_ops_defines.svh"
module skip_ops_monitor (
    input wire logic        pclk,           // clock
    input wire logic        presetn,        // async reset, low
    input wire logic        psel,           // apb select
    input wire logic        penable,        // apb enable
    input wire logic        pwrite,         // apb direction
    input wire logic [11:0] paddr,          // apb address
    input wire logic [31:0] pwdata,         // apb write data
    input wire logic        pready,         // apb ready
    input wire logic        pslverr,        // apb error
    input wire logic        int_vector_req, // vector request
    input wire logic        cpu_clk_en      // cpu clock running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase of any transfer
    wire acc_ph = psel && penable;
    // aligned offset inside the register map
    wire in_map = (paddr <= 12'h01C) && (paddr[1:0] == 2'b00);
    // completed control write, as plain booleans
    wire ctrl_wr_now = acc_ph && pready && pwrite && (paddr == `ADDR_CTRL);
    wire ctrl_wake   = ctrl_wr_now && !pwdata[`IDLE_BIT];
    // completed write of the control word
    sequence ctrl_wr;
        acc_ph && pready && pwrite && (paddr == `ADDR_CTRL);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    chk_err_unmapped: assert property (acc_ph && !in_map |-> pslverr)
        else $error("no error on unmapped access");
    chk_err_mapped: assert property (acc_ph && in_map |-> !pslverr)
        else $error("error on mapped access");
    chk_err_outside: assert property (!acc_ph |-> !pslverr)
        else $error("error outside access phase");
    chk_ready_mapped: assert property (acc_ph && paddr != `ADDR_FETCH |-> pready)
        else $error("wait state on register access");
    chk_vec_in_idle: assert property (!cpu_clk_en |-> !int_vector_req)
        else $error("vector request while execution halted");
    chk_idle_hold: assert property (!cpu_clk_en && !ctrl_wr_now |=> !cpu_clk_en)
        else $error("cpu clock restarted without control write");
    chk_idle_set: assert property (ctrl_wr and pwdata[`IDLE_BIT] |=> !cpu_clk_en)
        else $error("idle bit write did not stop clock");
    chk_clk_back: assert property ($rose(cpu_clk_en) |-> $past(ctrl_wake))
        else $error("cpu clock resumed without cause");
    chk_ime_clear: assert property (ctrl_wr and !pwdata[`IME_BIT] |=> !int_vector_req)
        else $error("vector request with master enable clear");
endmodule // skip_ops_monitor

// [tb/prog_mem_model.sv]
module prog_mem_model (
    input  wire logic [5:0] addr, // byte index
    output logic      [7:0] data  // instruction byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rom [0:32];
    // program table, opcode byte before its second byte
    // three fillers after halt
    initial rom = '{8'hFF, 8'hB2, 8'hFE, 8'hB2, 8'hFF, 8'hA3, 8'h00, 8'h00, 8'h00, 8'hD9, 8'h51, 8'h5F,
        8'h4A, 8'h5F, 8'h5A, 8'h5F, 8'h38, 8'h5F, 8'hDD, 8'h6B, 8'h5F, 8'hDD, 8'h73, 8'h5F,
        8'hDC, 8'h09, 8'h5F, 8'hDD, 8'h62, 8'h5F, 8'hCA, 8'h40, 8'h5F};
    assign data = rom[addr];
endmodule // prog_mem_model

// [tb/testbench.sv]
`include "skip_ops_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  int_source = 5'h00;
    logic        int_vector_req;
    logic        cpu_clk_en;
    logic [5:0]  rom_addr = 6'h00;
    logic [7:0]  rom_data;
    int          miscompares = 0;
    int          num_checks = 0;
    skip_interrupt_idle_ops u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_source(int_source), .int_vector_req(int_vector_req), .cpu_clk_en(cpu_clk_en));
    prog_mem_model u_rom (.addr(rom_addr), .data(rom_data));
    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] sel, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, sel, q, e);
        chk(q & m, x);
    endtask
    task automatic run(input int s, input int n);
        for (int i = 0; i < n; i++) begin
            rom_addr = 6'(s + i);
            #1;
            wr(`ADDR_FETCH, {24'h0, rom_data});
        end
    endtask
    // clear r7, run instruction and probe, r7 shows whether probe ran
    task automatic skip_case(input int s, input int n, input logic [3:0] ran);
        wr(`ADDR_REGS, 32'h70);
        run(s, n + 1);
        rdc(`ADDR_REGS, 32'h70, 32'hF, {28'h0, ran});
    endtask
    task automatic pulse(input logic [4:0] s);
        int_source <= s;
        @(posedge pclk);
        int_source <= 5'h00;
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic sc_reset();
        logic [31:0] q;
        logic        e;
        rdc(`ADDR_CTRL, 32'h0, 32'hC, 32'h0);
        chk({31'h0, cpu_clk_en}, 32'h1);
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic sc_int();
        pulse(5'h02);
        chk({31'h0, int_vector_req}, 32'h0);
        rdc(`ADDR_STATUS, 32'h0, 32'h1F, 32'h02);
        run(0, 2);
        rdc(`ADDR_CTRL, 32'h0, 32'h8, 32'h8);
        chk({31'h0, int_vector_req}, 32'h1);
        run(2, 2);
        rdc(`ADDR_CTRL, 32'h0, 32'h8, 32'h0);
        chk({31'h0, int_vector_req}, 32'h0);
        wr(`ADDR_STATUS, 32'h1F);
    endtask
    task automatic sc_idle();
        run(4, 2);
        rdc(`ADDR_CTRL, 32'h0, 32'h4, 32'h4);
        chk({31'h0, cpu_clk_en}, 32'h0);
        pulse(5'h01);
        rdc(`ADDR_STATUS, 32'h0, 32'h1F, 32'h01);
        wr(`ADDR_CTRL, 32'h4);
        chk({31'h0, cpu_clk_en}, 32'h0);
        wr(`ADDR_CTRL, 32'h0);
        run(6, 3);
        chk({31'h0, cpu_clk_en}, 32'h1);
        wr(`ADDR_STATUS, 32'h1F);
    endtask
    task automatic sc_skip();
        wr(`ADDR_REGS, 32'h15);
        wr(`ADDR_REGS, 32'h20);
        wr(`ADDR_REGS, 32'h33);
        wr(`ADDR_ACC, 32'h43);
        wr(`ADDR_PTR, 32'h40);
        wr(`ADDR_MEMSEL, 32'h41);
        wr(`ADDR_MEMDAT, 32'h4);
        wr(`ADDR_MEMSEL, 32'h40);
        wr(`ADDR_MEMDAT, 32'h3);
        skip_case(9, 2, 4'h0);
        rdc(`ADDR_REGS, 32'h10, 32'hF, 32'h5);
        skip_case(12, 1, 4'h0);
        rdc(`ADDR_REGS, 32'h20, 32'hF, 32'hF);
        skip_case(14, 1, 4'h0);
        rdc(`ADDR_REGS, 32'h20, 32'hF, 32'h0);
        skip_case(14, 1, 4'h1);
        skip_case(16, 1, 4'h0);
        skip_case(18, 2, 4'h0);
        skip_case(21, 2, 4'h0);
        skip_case(24, 2, 4'h0);
        skip_case(27, 2, 4'h1);
        rdc(`ADDR_MEMDAT, 32'h0, 32'hF, 32'h4);
        skip_case(30, 2, 4'h1);
        rdc(`ADDR_MEMDAT, 32'h0, 32'hF, 32'h5);
    endtask
    // watchdog cuts a hang short
    initial begin
        #200us;
        miscompares++;
        tally_and_finish();
    end
    // reset, then the scenarios
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        sc_reset();
        sc_int();
        sc_idle();
        sc_skip();
        tally_and_finish();
    end
endmodule // testbench
bind skip_interrupt_idle_ops skip_ops_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .int_vector_req(int_vector_req), .cpu_clk_en(cpu_clk_en));
